// *** rtl/watchdog_interval_timer.sv ***
module watchdog_interval_timer
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Register writes
  input  wire logic        i_ctrl_we,
  input  wire logic [15:0] i_ctrl_wdata,
  input  wire logic        i_reload_we,
  input  wire logic [15:0] i_reload_wdata,
  input  wire logic        i_count_we,
  input  wire logic [15:0] i_count_wdata,
  // Core status
  input  wire logic        i_core_debug_acknowledge,
  // Register views
  output logic      [15:0] o_wd_control_reg,
  output logic      [15:0] o_wd_reload_value_reg,
  output logic      [15:0] o_wd_count_reg,
  // Events
  output logic             o_irq,
  output logic             o_sys_rst
);

  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_RST  = 1'b1
  } rst_state_t;

  typedef struct packed
  {
    logic [15:0] ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    logic [7:0]  pre_cnt;
    logic [6:0]  div_cnt;
    logic [7:0]  rst_cnt;
    rst_state_t  st;
    logic        irq;
    logic        sys_rst;
    logic [8:0]  pulse_len;
    logic [15:0] gap;
    logic        gap_valid;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [6:0] div_last;
  logic       pre_done;
  logic       tick;
  logic       enabled;
  logic       timeout;

  always_comb
  begin
    case (s_r.ctrl[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB])
      2'h0:    div_last = 7'h0F;
      2'h1:    div_last = 7'h1F;
      2'h2:    div_last = 7'h3F;
      default: div_last = 7'h7F;
    endcase
  end

  assign enabled  = s_r.ctrl[wdt_pkg::EN_BIT];
  // Full 8-bit prescale compare, so 0 divides by one
  assign pre_done = s_r.pre_cnt == s_r.ctrl[wdt_pkg::PRE_MSB:wdt_pkg::PRE_LSB];
  assign tick     = enabled && pre_done && (s_r.div_cnt >= div_last);
  assign timeout  = tick && (s_r.count == 16'h0000);

  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.irq = 1'b0;
    if (i_ctrl_we)
      s_nxt.ctrl = i_ctrl_wdata;
    if (i_reload_we)
      s_nxt.reload = i_reload_wdata;
    // Prescaler chain held at zero while disabled, restarts cleanly on enable
    if (!enabled)
    begin
      s_nxt.pre_cnt = 8'h00;
      s_nxt.div_cnt = 7'h00;
    end
    else if (pre_done)
    begin
      s_nxt.pre_cnt = 8'h00;
      // >= guards against a select change shrinking the divider mid-count
      s_nxt.div_cnt = (s_r.div_cnt >= div_last) ? 7'h00
                                                : 7'(s_r.div_cnt + 7'h01);
    end
    else
      s_nxt.pre_cnt = 8'(s_r.pre_cnt + 8'h01);
    // Enable never touches the count; only ticks and writes do
    if (timeout)
      s_nxt.count = s_r.reload;
    else if (tick)
      s_nxt.count = 16'(s_r.count - 16'h0001);
    if (i_count_we)
      s_nxt.count = i_count_wdata;
    if (timeout && s_r.ctrl[wdt_pkg::INT_BIT])
      s_nxt.irq = 1'b1;
    // Checker-only pulse length, kept apart from the reset sequencer
    if (s_r.sys_rst)
      s_nxt.pulse_len = 9'(s_r.pulse_len + 9'h001);
    else
      s_nxt.pulse_len = 9'h000;
    // Checker-only tick spacing; a control write voids the measurement
    if (tick || i_ctrl_we || !enabled)
      s_nxt.gap = 16'h0000;
    else
      s_nxt.gap = 16'(s_r.gap + 16'h0001);
    if (i_ctrl_we || !enabled)
      s_nxt.gap_valid = 1'b0;
    else if (tick)
      s_nxt.gap_valid = 1'b1;
    case (s_r.st)
      ST_IDLE:
      begin
        if (timeout && s_r.ctrl[wdt_pkg::RST_BIT]
            && !i_core_debug_acknowledge)
        begin
          s_nxt.st      = ST_RST;
          s_nxt.rst_cnt = 8'h00;
          s_nxt.sys_rst = 1'b1;
        end
      end
      ST_RST:
      begin
        if (s_r.rst_cnt == wdt_pkg::RST_LAST)
        begin
          s_nxt.st      = ST_IDLE;
          s_nxt.sys_rst = 1'b0;
        end
        else
          s_nxt.rst_cnt = 8'(s_r.rst_cnt + 8'h01);
      end
      default:
      begin
        s_nxt.st      = ST_IDLE;
        s_nxt.sys_rst = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      s_r         <= '0;
      s_r.ctrl    <= wdt_pkg::CTRL_RESET;
      s_r.reload  <= wdt_pkg::RELOAD_RESET;
      s_r.count   <= wdt_pkg::COUNT_RESET;
      s_r.st      <= ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign o_wd_control_reg      = s_r.ctrl;
  assign o_wd_reload_value_reg = s_r.reload;
  assign o_wd_count_reg        = s_r.count;
  assign o_irq                 = s_r.irq;
  assign o_sys_rst             = s_r.sys_rst;

  // Assertions
  // Expected tick spacing, worked out from the control word alone
  logic [15:0] period;
  logic [2:0]  period_sh;
  assign period_sh = 3'h4 + 3'(s_r.ctrl[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB]);
  assign period    = 16'(16'(s_r.ctrl[wdt_pkg::PRE_MSB:wdt_pkg::PRE_LSB])
                         + 16'h0001) << period_sh;

  rst_length_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_sys_rst) |-> s_r.pulse_len == 9'h080)
    else $error("reset pulse not 128 cycles");
  rst_cap_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_r.pulse_len <= 9'h080)
    else $error("reset pulse too long");
  rst_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout && s_r.ctrl[wdt_pkg::RST_BIT] && !i_core_debug_acknowledge
    && !o_sys_rst |=> o_sys_rst)
    else $error("time-out missed reset");
  debug_block_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !o_sys_rst && i_core_debug_acknowledge |=> !o_sys_rst)
    else $error("reset during debug");
  irq_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_irq |-> $past(timeout) && $past(s_r.ctrl[wdt_pkg::INT_BIT]))
    else $error("spurious interrupt");
  reload_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout && !i_count_we |=> o_wd_count_reg == $past(o_wd_reload_value_reg))
    else $error("no reload at time-out");
  count_dec_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    tick && !timeout && !i_count_we
    |=> o_wd_count_reg == 16'($past(o_wd_count_reg) - 16'h0001))
    else $error("count did not decrement");
  hold_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !enabled && !i_count_we |=> $stable(o_wd_count_reg))
    else $error("disabled counter moved");
  tick_rate_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    tick && !i_ctrl_we
    && s_r.ctrl[wdt_pkg::PRE_MSB:wdt_pkg::PRE_LSB] == 8'h00
    && s_r.ctrl[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB] == wdt_pkg::DIV16_CODE
    |-> ##1 !tick [*8])
    else $error("tick too early");
  tick_period_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    tick && s_r.gap_valid |-> 16'(s_r.gap + 16'h0001) == period)
    else $error("tick period wrong");
  irq_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_irq |=> !o_irq)
    else $error("interrupt longer than one cycle");
  irq_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    timeout && !s_r.ctrl[wdt_pkg::INT_BIT] |=> !o_irq)
    else $error("interrupt while disabled");
  quiet_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !enabled && !o_sys_rst |=> !o_sys_rst && !o_irq)
    else $error("disabled timer raised event");

  rst_seen_c: cover property (@(posedge i_clk) $rose(o_sys_rst));
  irq_seen_c: cover property (@(posedge i_clk) o_irq);
  debug_mask_c: cover property (@(posedge i_clk)
    timeout && i_core_debug_acknowledge && s_r.ctrl[wdt_pkg::RST_BIT]);
  rst_end_c: cover property (@(posedge i_clk) $fell(o_sys_rst));
  div128_c: cover property (@(posedge i_clk)
    tick && s_r.ctrl[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB] == 2'h3);

endmodule

// *** rtl/wdt_pkg.sv ***
// Notes on behaviour
// - Time-out with reset enabled asserts system reset for exactly 128 clocks.
// - Usable as a plain 16-bit interval timer raising interrupts instead.
// - Tick comes from the clock via prescaler, then selected divider.
// - Prescaler accepts every value from 0 to 255.
// - Divider offers exactly 16, 32, 64 and 128.
// - Tick period is (prescaler+1) times division factor clock periods.
// - Enabling does not load the reload value; counter keeps its value.
// - Block watches the core debug acknowledge input.
// - While debug acknowledge is high, time-out asserts no reset.
// - Control bit 5 timer enable, bit 2 interrupt, bit 0 reset enable.
// - Control bits 15:8 prescaler, 4:3 divider select, 00 gives 16.
// - Each time-out reloads the counter from the reload value register; a count write in the same cycle wins.
package wdt_pkg;
  localparam logic [15:0] CTRL_RESET   = 16'h8021;
  localparam logic [15:0] RELOAD_RESET = 16'h8000;
  localparam logic [15:0] COUNT_RESET  = 16'h8000;
  localparam int          EN_BIT       = 5;
  localparam int          INT_BIT      = 2;
  localparam int          RST_BIT      = 0;
  localparam int          PRE_MSB      = 15;
  localparam int          PRE_LSB      = 8;
  localparam int          SEL_MSB      = 4;
  localparam int          SEL_LSB      = 3;
  localparam int          RST_CYCLES   = 128;
  localparam logic [7:0]  RST_LAST     = 8'(RST_CYCLES - 1);
  localparam logic [1:0]  DIV16_CODE   = 2'h0;
endpackage

// *** test/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk     = 1'b0;
  logic        i_rst_b   = 1'b0;
  logic        dbg       = 1'b0;
  logic [2:0]  we        = 3'h0;
  logic [15:0] wd        = 16'h0000;
  logic [15:0] ctrl_q;
  logic [15:0] rel_q;
  logic [15:0] cnt_q;
  logic        irq;
  logic        srst;
  int          bad_count = 0;
  int          tests_run = 0;
  int          n;
  int          m         = 0;

  always #20 i_clk = ~i_clk;

  watchdog_interval_timer DUT
  (
    .i_clk                    (i_clk),
    .i_rst_b                  (i_rst_b),
    .i_ctrl_we                (we[0]),
    .i_ctrl_wdata             (wd),
    .i_reload_we              (we[1]),
    .i_reload_wdata           (wd),
    .i_count_we               (we[2]),
    .i_count_wdata            (wd),
    .i_core_debug_acknowledge (dbg),
    .o_wd_control_reg         (ctrl_q),
    .o_wd_reload_value_reg    (rel_q),
    .o_wd_count_reg           (cnt_q),
    .o_irq                    (irq),
    .o_sys_rst                (srst)
  );

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Register index: 0 control, 1 reload, 2 count
  task wr(input int r, input logic [15:0] d);
    @(negedge i_clk);
    we[r] = 1'b1;
    wd = d;
    @(negedge i_clk);
    we = 3'h0;
  endtask

  task wait_irq;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (irq !== 1'b1 && n < 40000);
  endtask

  // Disabling clears the dividers, so timing starts at the enable edge
  task timed(input logic [15:0] c, input int exp);
    wr(0, 16'h0000);
    wr(2, 16'h0000);
    wr(0, c);
    wait_irq;
    chk(n, exp);
  endtask

  initial
  begin
    fork
      begin
        #800000;
        bad_count++;
        summarize;
      end
    join_none
    repeat (16) @(negedge i_clk);
    i_rst_b = 1'b1;
    chk(ctrl_q, 16'h8021);
    chk({rel_q, cnt_q}, 32'h80008000);
    chk({irq, srst}, 2'h0);
    // Disabled but with both events enabled: still nothing may fire
    wr(0, 16'h0005);
    wr(2, 16'h0005);
    repeat (300)
    begin
      @(negedge i_clk);
      m += (irq !== 1'b0 || srst !== 1'b0);
    end
    chk(m, 0);
    chk(cnt_q, 16'h0005);
    chk(ctrl_q, 16'h0005);
    wr(1, 16'h0003);
    chk(rel_q, 16'h0003);
    wr(2, 16'h0002);
    wr(0, 16'h0025);
    chk(cnt_q, 16'h0002);
    wait_irq;
    chk(n, 48);
    chk({srst, cnt_q}, {1'b1, 16'h0003});
    m = 0;
    while (srst === 1'b1 && m < 300)
    begin
      m++;
      @(negedge i_clk);
      if (m == 1)
        chk(irq, 1'b0);
    end
    chk(m, 128);
    // Interval mode: reset output left disabled, then 0025 with reset enabled under debug acknowledge
    for (int s = 0; s < 4; s++)
      timed({8'h01, 3'h1, 2'(s), 3'h4}, 2 * (16 << s));
    timed(16'hFF24, 4096);
    dbg = 1'b1;
    timed(16'h0025, 16);
    chk(srst, 1'b0);
    @(negedge i_clk);
    chk(srst, 1'b0);
    // Reset only, interrupt off, debug released
    dbg = 1'b0;
    wr(0, 16'h0000);
    wr(2, 16'h0000);
    wr(0, 16'h0021);
    m = 0;
    n = 0;
    while (srst !== 1'b1 && n < 40)
    begin
      @(negedge i_clk);
      n++;
      m += (irq !== 1'b0);
    end
    chk(n, 16);
    chk(m, 0);
    // Mid-pulse reset: two edges so the pulse cut is not seen as an end
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    chk({srst, ctrl_q}, {1'h0, 16'h8021});
    summarize;
  end
endmodule
